// >>> rtl/ccr_dbg_if.sv
// debug pin selection signals between the bank and its pin multiplexer
`timescale 1ns/100ps
interface ccr_dbg_if;
   logic [3:0] sel_tick;
   logic [3:0] sel_arm;
   logic [15:0] src;
   logic norm_tick;
   logic norm_arm;
   logic out_tick;
   logic out_arm;
   modport mux (
      input sel_tick,
      input sel_arm,
      input src,
      input norm_tick,
      input norm_arm,
      output out_tick,
      output out_arm
   );
   modport ctl (
      output sel_tick,
      output sel_arm,
      output src,
      output norm_tick,
      output norm_arm,
      input out_tick,
      input out_arm
   );
endinterface : ccr_dbg_if

// >>> rtl/ccr_dbg_mux.sv
// per-pin selection of normal function or a debug source
`timescale 1ns/100ps
module ccr_dbg_mux
   import ccr_pkg::*;
(
   ccr_dbg_if.mux dbg
);
   // two pins choose independently, same code allowed on both
   always_comb begin
      if (dbg.sel_tick == DBG_NORMAL) begin
         dbg.out_tick = dbg.norm_tick;
      end else begin
         dbg.out_tick = dbg.src[dbg.sel_tick];
      end
      if (dbg.sel_arm == DBG_NORMAL) begin
         dbg.out_arm = dbg.norm_arm;
      end else begin
         dbg.out_arm = dbg.src[dbg.sel_arm];
      end
   end
endmodule : ccr_dbg_mux

// >>> rtl/ccr_pkg.sv
// constants and types of the comm controller configuration bank
package ccr_pkg;
   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_MODULE_CTRL = 8'h00;
   localparam logic [7:0] OFF_DEBUG_PIN_SELECT = 8'h38;
   localparam logic [7:0] OFF_CONFIG_EXIT_DELAY = 8'h3c;
   localparam logic [7:0] OFF_NETMGMT_VECTOR_LENGTH = 8'h3e;
   localparam logic [7:0] OFF_SYNC_FRAME_IDENT = 8'h94;
   localparam logic [7:0] OFF_SYNC_HEADER_CHECKSUM = 8'h96;
   localparam logic [7:0] OFF_IDLE_DETECT_MINISLOTS = 8'haa;
   localparam logic [7:0] OFF_GUARDIAN_TICK_PERIOD = 8'hae;
   localparam logic [7:0] OFF_OFFSET_CORR_START_TIME = 8'he0;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_CONFIG_BIT = 0;
   localparam int CTRL_EXIT_PEND_BIT = 1;
   localparam int SYNC_SUP_BIT = 15;
   localparam int SYNC_ID_W = 11;
   localparam int CRC_W = 11;
   localparam int VLEN_W = 4;
   localparam int BGT_W = 5;
   localparam int IDLE_W = 4;
   localparam int SOC_W = 14;
   localparam int DLY_W = 16;
   localparam int SEL_W = 4;
   localparam int DATA_W = 16;
   localparam int TICK_SEL_LSB = 4;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   // exit delay is programmed in steps of eight microticks
   localparam int EXIT_STEP_SHIFT = 3;
   localparam int EXIT_CNT_W = DLY_W + EXIT_STEP_SHIFT;
   localparam logic [EXIT_CNT_W-1:0] EXIT_CNT_ONE = 19'h00001;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] RST_ZERO = 16'h0000;

   // ---------------------------------------------------------------
   // debug selection codes
   // ---------------------------------------------------------------
   localparam logic [SEL_W-1:0] DBG_NORMAL = 4'h0;
   localparam int DBG_CODES = 16;
   localparam logic [DBG_CODES-1:0] DBG_LEVEL_MASK = 16'h1010;

   typedef enum logic [1:0] {
      CCR_ST_CONFIG = 2'b00,
      CCR_ST_EXIT_WAIT = 2'b01,
      CCR_ST_RUN = 2'b10
   } ccr_state_t;
endpackage : ccr_pkg

// >>> rtl/ccr_top.sv
// comm controller configuration register bank with debug pin port
// ------------------------------------------------------------------
// Function
// - vector length 4 bits, 0..12, config only
// - sync id 11 bits; zero means no sync
// - sync register bit 15 marks startup node
// - sync header crc 11 bits, config only
// - matching sync buffer gets stored header crc
// - guardian tick period equals programmed microticks
// - leave config after delay times eight microticks
// - upper nibble tick pin, lower nibble arm
// - both pin selections independent of each other
// - code zero keeps normal guardian pin function
// - codes 1-3, 8-10 select protocol events
// - codes 4-7 select channel A signals
// - codes 12-15 select channel B signals
// - offset correction starts after programmed macroticks
// - idle check length 1..15 minislots
// - protocol fields config only; debug always writable
// - hard reset clears sync, length, delay, debug
// ------------------------------------------------------------------
`timescale 1ns/100ps
module ccr_top
   import ccr_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   // protocol timing inputs
   input wire logic macrotick_evt_i,
   input wire logic cycle_start_evt_i,
   input wire logic protocol_state_change_evt_i,
   input wire logic static_slot_start_evt_i,
   input wire logic minislot_start_evt_i,
   // channel A indications
   input wire logic filtered_rx_chan_a_i,
   input wire logic dyn_slot_start_chan_a_i,
   input wire logic frame_start_chan_a_i,
   input wire logic valid_frame_chan_a_i,
   // channel B indications
   input wire logic filtered_rx_chan_b_i,
   input wire logic dyn_slot_start_chan_b_i,
   input wire logic frame_start_chan_b_i,
   input wire logic valid_frame_chan_b_i,
   // transmit buffer header path
   input wire logic txbuf_sync_sel_i,
   input wire logic [10:0] txbuf_frame_id_i,
   input wire logic [10:0] txbuf_hdr_crc_i,
   output logic [10:0] tx_hdr_crc_o,
   // normal guardian arm function
   input wire logic guardian_arm_i,
   // guardian and debug pins
   output logic guardian_tick_pin_o,
   output logic guardian_arm_pin_o,
   // configuration seen by the protocol engine
   output logic config_state_o,
   output logic sync_tx_enable_o,
   output logic startup_node_flag_o,
   output logic [3:0] vector_len_bytes_o,
   output logic [3:0] idle_minislot_field_o,
   output logic offset_corr_start_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      ccr_state_t state;
      logic [EXIT_CNT_W-1:0] exit_cnt;
      logic [VLEN_W-1:0] vlen;
      logic [SYNC_ID_W-1:0] sync_id;
      logic startup_node_flag;
      logic [CRC_W-1:0] sync_crc;
      logic [BGT_W-1:0] guardian_tick_pin;
      logic [DLY_W-1:0] exit_dly;
      logic [2*SEL_W-1:0] dbg_sel;
      logic [SOC_W-1:0] soc_start;
      logic [IDLE_W-1:0] idle_len;
      logic [BGT_W-1:0] tick_cnt;
      logic tick;
      logic [SOC_W-1:0] mt_cnt;
      logic soc_pulse;
      logic [DBG_CODES-1:0] evt_q;
      logic [DATA_W-1:0] rdata;
      logic tick_pin;
      logic arm_pin;
      logic [CRC_W-1:0] hdr_crc;
      logic sync_tx_en;
   } ccr_regs_t;

   ccr_regs_t s;
   ccr_regs_t next_s;
   logic [DBG_CODES-1:0] dbg_raw;
   logic [DBG_CODES-1:0] dbg_src;
   logic cfg_write_ok;
   logic ctrl_wr;

   ccr_dbg_if dbg ();

   // ---------------------------------------------------------------
   // debug sources
   // ---------------------------------------------------------------
   always_comb begin
      dbg_raw = '0;
      dbg_raw[1] = protocol_state_change_evt_i;
      dbg_raw[2] = static_slot_start_evt_i;
      dbg_raw[3] = minislot_start_evt_i;
      dbg_raw[4] = filtered_rx_chan_a_i;
      dbg_raw[5] = dyn_slot_start_chan_a_i;
      dbg_raw[6] = frame_start_chan_a_i;
      dbg_raw[7] = valid_frame_chan_a_i;
      dbg_raw[8] = cycle_start_evt_i;
      dbg_raw[9] = macrotick_evt_i;
      dbg_raw[10] = s.soc_pulse;
      dbg_raw[12] = filtered_rx_chan_b_i;
      dbg_raw[13] = dyn_slot_start_chan_b_i;
      dbg_raw[14] = frame_start_chan_b_i;
      dbg_raw[15] = valid_frame_chan_b_i;
   end

   // events become one-cycle pulses even if the source stretches them
   genvar gi;
   generate
      for (gi = 0; gi < DBG_CODES; gi++) begin : g_src
         if (DBG_LEVEL_MASK[gi]) begin : g_level
            assign dbg_src[gi] = dbg_raw[gi];
         end else begin : g_event
            assign dbg_src[gi] = dbg_raw[gi] & ~s.evt_q[gi];
         end
      end
   endgenerate

   assign dbg.sel_tick = s.dbg_sel[2*SEL_W-1:TICK_SEL_LSB];
   assign dbg.sel_arm = s.dbg_sel[SEL_W-1:0];
   assign dbg.src = dbg_src;
   assign dbg.norm_tick = s.tick;
   assign dbg.norm_arm = guardian_arm_i;

   ccr_dbg_mux u_dbg_mux (
      .dbg(dbg.mux)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   assign cfg_write_ok = reg_wr_i && (s.state == CCR_ST_CONFIG);
   assign ctrl_wr = reg_wr_i && (reg_addr_i == OFF_MODULE_CTRL);

   always_comb begin
      next_s = s;
      next_s.evt_q = dbg_raw;
      next_s.tick_pin = dbg.out_tick;
      next_s.arm_pin = dbg.out_arm;
      next_s.rdata = RST_ZERO;

      // debug selection may change in any state
      if (reg_wr_i && reg_addr_i == OFF_DEBUG_PIN_SELECT) begin
         next_s.dbg_sel = reg_wdata_i[2*SEL_W-1:0];
      end

      // protocol fields only while configuring
      if (cfg_write_ok) begin
         case (reg_addr_i)
            OFF_CONFIG_EXIT_DELAY: begin
               next_s.exit_dly = reg_wdata_i;
            end
            OFF_NETMGMT_VECTOR_LENGTH: begin
               next_s.vlen = reg_wdata_i[VLEN_W-1:0];
            end
            OFF_SYNC_FRAME_IDENT: begin
               next_s.sync_id = reg_wdata_i[SYNC_ID_W-1:0];
               next_s.startup_node_flag = reg_wdata_i[SYNC_SUP_BIT];
            end
            OFF_SYNC_HEADER_CHECKSUM: begin
               next_s.sync_crc = reg_wdata_i[CRC_W-1:0];
            end
            OFF_IDLE_DETECT_MINISLOTS: begin
               next_s.idle_len = reg_wdata_i[IDLE_W-1:0];
            end
            OFF_GUARDIAN_TICK_PERIOD: begin
               next_s.guardian_tick_pin = reg_wdata_i[BGT_W-1:0];
            end
            OFF_OFFSET_CORR_START_TIME: begin
               next_s.soc_start = reg_wdata_i[SOC_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // configuration state sequencing
      case (s.state)
         CCR_ST_CONFIG: begin
            if (ctrl_wr && !reg_wdata_i[CTRL_CONFIG_BIT]) begin
               // zero delay leaves on the very next edge
               next_s.exit_cnt = EXIT_CNT_W'(s.exit_dly) << EXIT_STEP_SHIFT;
               if (s.exit_dly == RST_ZERO) begin
                  next_s.state = CCR_ST_RUN;
               end else begin
                  next_s.state = CCR_ST_EXIT_WAIT;
               end
            end
         end
         CCR_ST_EXIT_WAIT: begin
            if (ctrl_wr && reg_wdata_i[CTRL_CONFIG_BIT]) begin
               next_s.state = CCR_ST_CONFIG;
            end else if (s.exit_cnt == EXIT_CNT_ONE) begin
               next_s.state = CCR_ST_RUN;
            end else begin
               next_s.exit_cnt = s.exit_cnt - EXIT_CNT_ONE;
            end
         end
         CCR_ST_RUN: begin
            if (ctrl_wr && reg_wdata_i[CTRL_CONFIG_BIT]) begin
               next_s.state = CCR_ST_CONFIG;
            end
         end
         default: begin
            next_s.state = CCR_ST_CONFIG;
         end
      endcase

      // guardian tick: one pulse per programmed number of microticks
      next_s.tick = 1'b0;
      if (s.state == CCR_ST_CONFIG) begin
         next_s.tick_cnt = '0;
      end else if (s.tick_cnt >= s.guardian_tick_pin - 5'h1) begin
         next_s.tick_cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.tick_cnt = s.tick_cnt + 5'h1;
      end

      // offset correction start, macroticks counted from cycle start
      next_s.soc_pulse = 1'b0;
      if (cycle_start_evt_i) begin
         next_s.mt_cnt = '0;
      end else if (macrotick_evt_i) begin
         next_s.mt_cnt = s.mt_cnt + 14'h1;
         if (s.mt_cnt == s.soc_start && s.state != CCR_ST_CONFIG) begin
            next_s.soc_pulse = 1'b1;
         end
      end

      // sync header crc substitution on the transmit path
      next_s.hdr_crc = txbuf_hdr_crc_i;
      if (txbuf_sync_sel_i && txbuf_frame_id_i == s.sync_id &&
          s.sync_id != '0) begin
         next_s.hdr_crc = s.sync_crc;
      end
      next_s.sync_tx_en = (s.sync_id != '0);

      // read data stands only in the cycle after the strobe
      if (reg_rd_i) begin
         case (reg_addr_i)
            OFF_MODULE_CTRL: begin
               next_s.rdata[CTRL_CONFIG_BIT] = (s.state == CCR_ST_CONFIG);
               next_s.rdata[CTRL_EXIT_PEND_BIT] =
                  (s.state == CCR_ST_EXIT_WAIT);
            end
            OFF_DEBUG_PIN_SELECT: begin
               next_s.rdata[2*SEL_W-1:0] = s.dbg_sel;
            end
            OFF_CONFIG_EXIT_DELAY: begin
               next_s.rdata = s.exit_dly;
            end
            OFF_NETMGMT_VECTOR_LENGTH: begin
               next_s.rdata[VLEN_W-1:0] = s.vlen;
            end
            OFF_SYNC_FRAME_IDENT: begin
               next_s.rdata[SYNC_ID_W-1:0] = s.sync_id;
               next_s.rdata[SYNC_SUP_BIT] = s.startup_node_flag;
            end
            OFF_SYNC_HEADER_CHECKSUM: begin
               next_s.rdata[CRC_W-1:0] = s.sync_crc;
            end
            OFF_IDLE_DETECT_MINISLOTS: begin
               next_s.rdata[IDLE_W-1:0] = s.idle_len;
            end
            OFF_GUARDIAN_TICK_PERIOD: begin
               next_s.rdata[BGT_W-1:0] = s.guardian_tick_pin;
            end
            OFF_OFFSET_CORR_START_TIME: begin
               next_s.rdata[SOC_W-1:0] = s.soc_start;
            end
            default: begin
               next_s.rdata = RST_ZERO;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // fields of undefined reset value are cleared too, for determinism
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata_o = s.rdata;
   assign tx_hdr_crc_o = s.hdr_crc;
   assign guardian_tick_pin_o = s.tick_pin;
   assign guardian_arm_pin_o = s.arm_pin;
   assign config_state_o = (s.state == CCR_ST_CONFIG);
   assign sync_tx_enable_o = s.sync_tx_en;
   assign startup_node_flag_o = s.startup_node_flag;
   assign vector_len_bytes_o = s.vlen;
   assign idle_minislot_field_o = s.idle_len;
   assign offset_corr_start_o = s.soc_pulse;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   chk_cfg_write_lock: assert property (
      reg_wr_i && reg_addr_i == OFF_NETMGMT_VECTOR_LENGTH &&
      s.state != CCR_ST_CONFIG |=> $stable(vector_len_bytes_o))
      else $error("vector length changed outside configuration");

   chk_sync_zero_off: assert property (
      s.sync_id == '0 |=> !sync_tx_enable_o)
      else $error("sync transmit enabled with zero identifier");

   chk_startup_flag: assert property (
      cfg_write_ok && reg_addr_i == OFF_SYNC_FRAME_IDENT
      |=> startup_node_flag_o == $past(reg_wdata_i[SYNC_SUP_BIT]))
      else $error("startup flag not taken from bit 15");

   chk_crc_replace: assert property (
      txbuf_sync_sel_i && txbuf_frame_id_i == s.sync_id &&
      s.sync_id != '0 |=> tx_hdr_crc_o == $past(s.sync_crc))
      else $error("sync header crc not substituted");

   chk_tick_period: assert property (
      s.tick && s.guardian_tick_pin == 5'h3 && s.state == CCR_ST_RUN && !ctrl_wr
      |=> !s.tick ##1 !s.tick ##1
      (s.tick || $past(ctrl_wr && reg_wdata_i[CTRL_CONFIG_BIT], 2)))
      else $error("guardian tick period wrong");

   chk_exit_delay: assert property (
      s.state == CCR_ST_CONFIG && ctrl_wr &&
      !reg_wdata_i[CTRL_CONFIG_BIT] && s.exit_dly != RST_ZERO
      |=> s.state == CCR_ST_EXIT_WAIT && !config_state_o)
      else $error("configuration left without exit delay");

   chk_exit_count: assert property (
      s.state == CCR_ST_CONFIG && ctrl_wr &&
      !reg_wdata_i[CTRL_CONFIG_BIT] && s.exit_dly == 16'h0001
      ##1 (!ctrl_wr)[*8]
      |=> s.state == CCR_ST_RUN && $past(s.state) == CCR_ST_EXIT_WAIT)
      else $error("configuration exit delay not eight microticks");

   chk_dbg_normal: assert property (
      s.dbg_sel[SEL_W-1:0] == DBG_NORMAL
      |=> guardian_arm_pin_o == $past(guardian_arm_i))
      else $error("arm pin left normal function on code zero");

   chk_dbg_level_a: assert property (
      s.dbg_sel[2*SEL_W-1:TICK_SEL_LSB] == 4'h4
      |=> guardian_tick_pin_o == $past(filtered_rx_chan_a_i))
      else $error("tick pin does not follow channel A receive line");

   chk_soc_start: assert property (
      macrotick_evt_i && !cycle_start_evt_i &&
      s.mt_cnt == s.soc_start && s.state != CCR_ST_CONFIG
      |=> offset_corr_start_o ##1 !offset_corr_start_o)
      else $error("offset correction start not pulsed");

endmodule : ccr_top

// >>> test/ccr_proto_model.sv
// protocol engine timing model: free-running macroticks and cycle starts
`timescale 1ns/100ps
module ccr_proto_model #(
   parameter int MT_LEN = 3,
   parameter int CYC_MT = 8
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // timing events
   output logic macrotick_evt_o,
   output logic cycle_start_evt_o
);
   int ut_cnt;
   int mt_cnt;

   // strictly periodic so that a window of one cycle length sees exact counts
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ut_cnt <= 0;
         mt_cnt <= 0;
         macrotick_evt_o <= 1'b0;
         cycle_start_evt_o <= 1'b0;
      end else begin
         macrotick_evt_o <= (ut_cnt == MT_LEN - 1);
         cycle_start_evt_o <= (ut_cnt == MT_LEN - 1) && (mt_cnt == 0);
         if (ut_cnt == MT_LEN - 1) begin
            ut_cnt <= 0;
            mt_cnt <= (mt_cnt == CYC_MT - 1) ? 0 : mt_cnt + 1;
         end else begin
            ut_cnt <= ut_cnt + 1;
         end
      end
   end
endmodule : ccr_proto_model

// >>> test/tb.sv
// self-checking bench of the configuration register bank
`timescale 1ns/100ps
`define CHK(name, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("CHECK FAILED %s exp %h got %h", name, exp, got); \
      end \
   end
module tb;
   import ccr_pkg::*;
   localparam int MT_LEN = 3;
   localparam int CYC_MT = 8;
   localparam logic [7:0] OFFS [8] = '{OFF_NETMGMT_VECTOR_LENGTH,
      OFF_SYNC_FRAME_IDENT, OFF_SYNC_HEADER_CHECKSUM,
      OFF_IDLE_DETECT_MINISLOTS, OFF_GUARDIAN_TICK_PERIOD,
      OFF_OFFSET_CORR_START_TIME, OFF_CONFIG_EXIT_DELAY, OFF_DEBUG_PIN_SELECT};
   // all-ones writes still keep length and tick period in range
   localparam logic [15:0] ONES [8] = '{16'hfffc, 16'hffff, 16'hffff,
      16'hffff, 16'hfff0, 16'hffff, 16'hffff, 16'hffff};
   localparam logic [15:0] MASKS [8] = '{16'h000c, 16'h87ff, 16'h07ff,
      16'h000f, 16'h0010, 16'h3fff, 16'hffff, 16'h00ff};
   // start time 3 is taken as past idle start plus the minimum interval
   localparam logic [15:0] VALS [8] = '{16'h000c, 16'h07ff, 16'h05a5,
      16'h000f, 16'h0003, 16'h0003, 16'h0001, 16'h0000};
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic core_clk_i, rstn_i, wr, rd, mt, cs, tsel, garm;
   logic tick_pin, arm_pin, cfg, sync_en, startup_node_flag, soc;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, ev;
   logic [10:0] tid, tcrc, hcrc;
   logic [3:0] vlen, idle;
   int fail_count = 0;
   int cmp_count = 0;

   ccr_proto_model #(.MT_LEN(MT_LEN), .CYC_MT(CYC_MT)) i_proto (
      .core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .macrotick_evt_o(mt), .cycle_start_evt_o(cs));
   ccr_top i_dut (
      .core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata),
      .macrotick_evt_i(mt), .cycle_start_evt_i(cs),
      .protocol_state_change_evt_i(ev[1]),
      .static_slot_start_evt_i(ev[2]), .minislot_start_evt_i(ev[3]),
      .filtered_rx_chan_a_i(ev[4]), .dyn_slot_start_chan_a_i(ev[5]),
      .frame_start_chan_a_i(ev[6]), .valid_frame_chan_a_i(ev[7]),
      .filtered_rx_chan_b_i(ev[12]), .dyn_slot_start_chan_b_i(ev[13]),
      .frame_start_chan_b_i(ev[14]), .valid_frame_chan_b_i(ev[15]),
      .txbuf_sync_sel_i(tsel), .txbuf_frame_id_i(tid),
      .txbuf_hdr_crc_i(tcrc), .tx_hdr_crc_o(hcrc),
      .guardian_arm_i(garm), .guardian_tick_pin_o(tick_pin),
      .guardian_arm_pin_o(arm_pin), .config_state_o(cfg),
      .sync_tx_enable_o(sync_en), .startup_node_flag_o(startup_node_flag),
      .vector_len_bytes_o(vlen), .idle_minislot_field_o(idle),
      .offset_corr_start_o(soc));

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : cyc

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge core_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1;
      `CHK("read data", exp, rdata)
   endtask : rd_chk

   task automatic tx_chk(input logic s, input logic [10:0] id,
                         input logic [10:0] exp);
      @(posedge core_clk_i);
      tsel <= s;
      tid <= id;
      tcrc <= 11'h111;
      @(posedge core_clk_i);
      #1;
      `CHK("tx header crc", exp, hcrc)
   endtask : tx_chk

   // pin pulses are counted from the moment the source is raised
   task automatic dbg_code(input logic [3:0] c, input int hold,
                           input int n, input int exp);
      int nt;
      int na;
      nt = 0;
      na = 0;
      wr_reg(OFF_DEBUG_PIN_SELECT, {8'h00, c, c});
      cyc(3);
      ev[c] <= 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk_i);
         if (i == hold - 1) ev[c] <= 1'b0;
         #1;
         if (tick_pin === 1'b1) nt++;
         if (arm_pin === 1'b1) na++;
      end
      `CHK("tick pin pulses", exp, nt)
      `CHK("arm pin pulses", exp, na)
   endtask : dbg_code

   task automatic tick_period(input int exp);
      int k;
      k = 0;
      while (tick_pin !== 1'b1 && k < 40) begin
         @(posedge core_clk_i);
         #1;
         k++;
      end
      k = 0;
      do begin
         @(posedge core_clk_i);
         #1;
         k++;
      end while (tick_pin !== 1'b1 && k < 40);
      `CHK("tick period", exp, k)
   endtask : tick_period

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      #100us;
      fail_count++;
      stop_test();
   end
   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      int n;
      n = 0;
      rstn_i = 1'b0;
      {wr, rd, tsel, garm} = 4'h0;
      addr = 8'h00;
      wdata = 16'h0000;
      ev = 16'h0000;
      tid = 11'h000;
      tcrc = 11'h000;
      cyc(10);
      rstn_i <= 1'b1;
      for (int i = 0; i < 8; i++) rd_chk(OFFS[i], 16'h0000);
      rd_chk(OFF_MODULE_CTRL, 16'h0001);
      rd_chk(8'h02, 16'h0000);
      `CHK("config state", 1'b1, cfg)
      for (int i = 0; i < 30; i++) begin
         @(posedge core_clk_i);
         #1;
         if (tick_pin === 1'b1 || soc === 1'b1) n++;
      end
      `CHK("pulses in config", 0, n)
      for (int i = 0; i < 8; i++) begin
         wr_reg(OFFS[i], ONES[i]);
         rd_chk(OFFS[i], MASKS[i]);
      end
      wr_reg(OFF_SYNC_FRAME_IDENT, 16'h8000);
      cyc(2);
      #1;
      `CHK("startup flag", 1'b1, startup_node_flag)
      `CHK("sync enable", 1'b0, sync_en)
      for (int i = 0; i < 8; i++) wr_reg(OFFS[i], VALS[i]);
      cyc(2);
      #1;
      `CHK("startup flag", 1'b0, startup_node_flag)
      `CHK("sync enable", 1'b1, sync_en)
      `CHK("vector length", 4'hc, vlen)
      `CHK("idle length", 4'hf, idle)
      tx_chk(1'b1, 11'h7ff, 11'h5a5);
      tx_chk(1'b1, 11'h7fe, 11'h111);
      tx_chk(1'b0, 11'h7ff, 11'h111);
      // exit delay 1 gives eight cycles of waiting
      wr_reg(OFF_MODULE_CTRL, 16'h0000);
      cyc(6);
      rd_chk(OFF_MODULE_CTRL, 16'h0002);
      rd_chk(OFF_MODULE_CTRL, 16'h0000);
      `CHK("config state", 1'b0, cfg)
      wr_reg(OFF_NETMGMT_VECTOR_LENGTH, 16'h0005);
      rd_chk(OFF_NETMGMT_VECTOR_LENGTH, 16'h000c);
      wr_reg(OFF_SYNC_FRAME_IDENT, 16'h0000);
      rd_chk(OFF_SYNC_FRAME_IDENT, 16'h07ff);
      tick_period(3);
      @(posedge core_clk_i);
      garm <= 1'b1;
      cyc(3);
      #1;
      `CHK("arm pin normal", 1'b1, arm_pin)
      for (int c = 1; c < 16; c++) begin
         case (c)
            4, 12: dbg_code(c, 3, 10, 3);
            8: dbg_code(c, 1, MT_LEN * CYC_MT, 1);
            9: dbg_code(c, 1, MT_LEN * CYC_MT, CYC_MT);
            10: dbg_code(c, 1, MT_LEN * CYC_MT, 1);
            11: dbg_code(c, 1, 10, 0);
            default: dbg_code(c, 3, 10, 1);
         endcase
      end
      wr_reg(OFF_DEBUG_PIN_SELECT, 16'h004c);
      ev[4] <= 1'b1;
      cyc(4);
      #1;
      `CHK("tick pin channel a", 1'b1, tick_pin)
      `CHK("arm pin channel b", 1'b0, arm_pin)
      ev[4] <= 1'b0;
      wr_reg(OFF_DEBUG_PIN_SELECT, 16'h0000);
      wr_reg(OFF_MODULE_CTRL, 16'h0001);
      #1;
      `CHK("config state", 1'b1, cfg)
      wr_reg(OFF_CONFIG_EXIT_DELAY, 16'h0000);
      for (int v = 2; v <= 16; v += 14) begin
         wr_reg(OFF_MODULE_CTRL, 16'h0001);
         wr_reg(OFF_GUARDIAN_TICK_PERIOD, 16'(v));
         wr_reg(OFF_MODULE_CTRL, 16'h0000);
         tick_period(v);
      end
      @(posedge core_clk_i);
      rstn_i <= 1'b0;
      cyc(2);
      rstn_i <= 1'b1;
      rd_chk(OFF_SYNC_FRAME_IDENT, 16'h0000);
      rd_chk(OFF_MODULE_CTRL, 16'h0001);
      stop_test();
   end
endmodule : tb
